// ==== rtl/hsel_spi_slave.sv ====
// host port type selection and spi register slave
//
// Summary of operation
// [R1] Port logic resets and port type is re-sampled after power-up or wake.
// [R2] Port type comes from strap pin levels sampled after cold reset.
// [R3] Straps 00 UART, 10 SPI (strap1 high), 01 I2C, 11 alternate I2C.
// [R4] Shared pins 0..3 map to each port's signals per selected type; only the SPI mapping is built here, other types' pins are ignored.
// [R5] Device is SPI slave only; master makes the serial clock.
// [R6] Commands and write data on MOSI; read data returned on MISO.
// [R7] Slave works up to 10 Mbit/s; master never clocks faster.
// [R8] Select high disables the SPI port and resets transfer state.
// [R9] Master raises select between successive commands.
// [R10] Bytes go MSB first on MOSI and MISO.
// [R11] Master changes MOSI on falling edges, stable at rising edges.
// [R12] Device updates MISO on falling edges, stable at rising edges.
// [R13] Master holds serial clock low at idle.
// [R14] First byte: address in bits 7..1, bit 0 one means read.
// [R15] Read: each address byte returns its data one byte later.
// [R16] Burst writes increment address except at the FIFO address.
// [R17] Port type stays latched until next power-up or wake.
// [R18] A partial byte at select rise is discarded without access.
`timescale 1ns/1ns
`include "hsel_defs.svh"

module hsel_spi_slave (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // power-up or wake pulse, same domain
    input wire logic wake_pulse,
    // straps and shared host pins
    input wire logic host_type_strap_0,
    input wire logic host_type_strap_1,
    input wire logic host_pin_0,
    input wire logic host_pin_1,
    input wire logic host_pin_3,
    output logic host_pin_2_out,
    output logic host_pin_2_oe,
    // selected port type
    output logic [1:0] port_type,
    output logic port_valid,
    // register access toward the core
    output logic reg_wr,
    output logic reg_rd,
    output logic [6:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    // two-flop synchronisers for straps and pins
    // reset to idle levels: select high, clock and data low
    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    logic [4:0] pins_in;
    assign pins_in = {host_type_strap_1, host_type_strap_0,
                      host_pin_3, host_pin_1, host_pin_0};
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            sync1_r <= `HSEL_SYNC_IDLE;
            sync2_r <= `HSEL_SYNC_IDLE;
        end else begin
            sync1_r <= pins_in;
            sync2_r <= sync1_r;
        end
    end
    wire logic strap1_s = sync2_r[4];
    wire logic strap0_s = sync2_r[3];
    wire logic nss_s = sync2_r[2];
    wire logic sck_s = sync2_r[1];
    wire logic mosi_s = sync2_r[0];

    // port type latch: straps read four edges after reset or wake,
    // once the synchroniser holds settled pin levels
    logic [1:0] sample_cnt_r;
    logic [1:0] type_r;
    logic valid_r;
    // [R1] reset and re-sample
    wire logic restart = wake_pulse;
    always_ff @(posedge sys_clk) begin
        if (!rstn || restart) begin
            sample_cnt_r <= 2'h0;
            valid_r <= 1'b0;
            type_r <= hsel_pkg::HSEL_UART;
        // [R2] [R3] [R17] sample once, then hold
        end else if (!valid_r) begin
            if (sample_cnt_r == `HSEL_SAMPLE_LAST) begin
                // strap 1 is the high bit: 2 is spi, 1 standard i2c
                type_r <= {strap1_s, strap0_s};
                valid_r <= 1'b1;
            end else begin
                sample_cnt_r <= sample_cnt_r + 2'h1;
            end
        end
    end
    assign port_type = type_r;
    assign port_valid = valid_r;

    // [R4] [R17] spi only when selected; other types' pins ignored here
    wire logic spi_on = valid_r && (type_r == hsel_pkg::HSEL_SPI);
    // a select seen before the type is latched counts for nothing
    // [R8] select high keeps port in reset
    wire logic sel = spi_on && !nss_s;

    // limitation: each serial clock phase must span over three system
    // clocks, so the top bit rate sits well below the system clock rate
    // [R7] rate bounded by sampling
    // [R5] edges of master-driven clock, found by the system clock
    // resets to the idle low level, so no false rise follows reset
    logic sck_d_r;
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            sck_d_r <= 1'b0;
        end else begin
            sck_d_r <= sck_s;
        end
    end
    wire logic sck_rise = sel && sck_s && !sck_d_r;
    wire logic sck_fall = sel && !sck_s && sck_d_r;

    hsel_pkg::hsel_state_type state_r, state_nxt;
    logic [2:0] bit_r;
    logic [7:0] shin_r;
    logic [7:0] shout_r;
    logic rd_r;
    logic [6:0] addr_r;
    logic wr_r, rdp_r;
    logic [7:0] wd_r;
    logic miso_r, oe_r;

    // [R10] msb first in
    wire logic [7:0] byte_in = {shin_r[6:0], mosi_s};
    wire logic byte_done = sck_rise && (bit_r == `HSEL_BIT_LAST);
    wire logic [6:0] rx_addr = byte_in[`HSEL_ADDR_MSB:`HSEL_ADDR_LSB];
    // [R14] direction flag in bit 0
    wire logic rx_read = byte_in[`HSEL_RW_BIT];
    wire logic first_byte = (state_r == hsel_pkg::HSEL_ST_ADDR);
    // [R16] fifo address does not advance
    wire logic [6:0] next_waddr = (addr_r == `HSEL_FIFO_ADDR) ? addr_r : addr_r + 7'h01;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            hsel_pkg::HSEL_ST_IDLE: if (sel) state_nxt = hsel_pkg::HSEL_ST_ADDR;
            hsel_pkg::HSEL_ST_ADDR: if (byte_done) state_nxt = hsel_pkg::HSEL_ST_DATA;
            hsel_pkg::HSEL_ST_DATA: state_nxt = hsel_pkg::HSEL_ST_DATA;
            default: state_nxt = hsel_pkg::HSEL_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        // [R8] [R18] select high drops partial byte and state
        if (!rstn || !sel) begin
            state_r <= hsel_pkg::HSEL_ST_IDLE;
            bit_r <= `HSEL_BIT_FIRST;
            shin_r <= 8'h00;
            rd_r <= 1'b0;
            addr_r <= 7'h00;
        end else begin
            state_r <= state_nxt;
            // [R11] sample on rising edge
            if (sck_rise) begin
                shin_r <= byte_in;
                bit_r <= bit_r + 3'h1;
            end
            if (byte_done && first_byte) begin
                addr_r <= rx_addr;
                rd_r <= rx_read;
            end else if (byte_done && !rd_r) begin
                addr_r <= next_waddr;
            end else if (byte_done) begin
                // [R15] every byte of a read is the next address
                addr_r <= rx_addr;
            end
        end
    end

    // register strobes: one cycle each
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            wr_r <= 1'b0;
            rdp_r <= 1'b0;
            wd_r <= 8'h00;
        end else begin
            // [R6] write data from mosi
            wr_r <= sel && byte_done && !first_byte && !rd_r;
            // the closing byte of a read is fetched too; the slave cannot
            // tell it from a further address until select rises
            // [R15] read fetch on each address byte
            rdp_r <= sel && byte_done && (first_byte ? rx_read : rd_r);
            // data follows the shifter; meaningful only with the strobe
            wd_r <= byte_in;
        end
    end
    logic [6:0] ra_r;
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ra_r <= 7'h00;
        end else if (sel && byte_done) begin
            ra_r <= (first_byte || rd_r) ? rx_addr : addr_r;
        end
    end
    assign reg_wr = wr_r;
    assign reg_rd = rdp_r;
    assign reg_addr = ra_r;
    assign reg_wdata = wd_r;

    // [R12] [R10] miso shifts msb first on falling edges
    always_ff @(posedge sys_clk) begin
        if (!rstn || !sel) begin
            shout_r <= 8'h00;
            miso_r <= `HSEL_MISO_IDLE;
            oe_r <= 1'b0;
        end else begin
            oe_r <= 1'b1;
            // reload lands well before the first falling edge of next byte
            if (rdp_r) begin
                shout_r <= reg_rdata;
            end else if (sck_fall) begin
                miso_r <= shout_r[7];
                shout_r <= {shout_r[6:0], 1'b0};
            end
        end
    end
    assign host_pin_2_out = miso_r;
    assign host_pin_2_oe = oe_r;
endmodule // hsel_spi_slave

// ==== rtl/hsel_defs.svh ====
// constants for the host port selector and spi slave
`ifndef HSEL_DEFS_SVH
`define HSEL_DEFS_SVH
`define HSEL_RW_BIT 0
`define HSEL_ADDR_MSB 7
`define HSEL_ADDR_LSB 1
`define HSEL_BIT_LAST 3'h7
`define HSEL_BIT_FIRST 3'h0
`define HSEL_SAMPLE_LAST 2'h3
`define HSEL_SYNC_IDLE 5'h04
`define HSEL_FIFO_ADDR 7'h05
`define HSEL_MISO_IDLE 1'h0
`define HSEL_SPI_MAX_KBPS 10000
`endif

// ==== rtl/hsel_pkg.sv ====
// types for the host port selector and spi slave
package hsel_pkg;
    typedef enum logic [1:0] {
        HSEL_UART = 2'h0,
        HSEL_SPI = 2'h2,
        HSEL_I2C = 2'h1,
        HSEL_I2CL = 2'h3
    } hsel_port_type;
    // gray along idle -> address -> data
    typedef enum logic [1:0] {
        HSEL_ST_IDLE = 2'h0,
        HSEL_ST_ADDR = 2'h1,
        HSEL_ST_DATA = 2'h3
    } hsel_state_type;
endpackage

// ==== bench/hsel_spi_slave_chk.sv ====
// port assertions for the host port selector and spi slave
`timescale 1ns/1ns
module hsel_spi_slave_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // watched ports
    input wire logic wake_pulse,
    input wire logic host_pin_1,
    input wire logic host_pin_3,
    input wire logic host_pin_2_out,
    input wire logic host_pin_2_oe,
    input wire logic [1:0] port_type,
    input wire logic port_valid,
    input wire logic reg_wr,
    input wire logic reg_rd
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    property p_strobe_one; (reg_wr || reg_rd) |=> !(reg_wr || reg_rd); endproperty
    a_strobe_one: assert property (p_strobe_one) else $error("strobe too long");
    property p_excl; !(reg_wr && reg_rd); endproperty
    a_excl: assert property (p_excl) else $error("read and write together");
    // margin covers sync delay after the last bit
    property p_idle_quiet; host_pin_3 [*4] |-> !reg_wr && !reg_rd; endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("access while deselected");
    property p_oe_off; host_pin_3 [*5] |-> !host_pin_2_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("miso driven while deselected");
    property p_spi_only; (reg_wr || reg_rd) |-> port_valid && port_type == 2'h2; endproperty
    a_spi_only: assert property (p_spi_only) else $error("access outside spi type");
    property p_miso_fall; host_pin_2_oe && $past(host_pin_2_oe) && $changed(host_pin_2_out)
        |-> !host_pin_1; endproperty
    a_miso_fall: assert property (p_miso_fall) else $error("miso moved with clock high");
    property p_type_hold; port_valid && $stable(port_valid) |-> $stable(port_type); endproperty
    a_type_hold: assert property (p_type_hold) else $error("port type moved");
    property p_valid_up; $rose(rstn) || wake_pulse |-> ##[1:12] port_valid; endproperty
    a_valid_up: assert property (p_valid_up) else $error("port type not latched");
    cover property (reg_wr);
    cover property (reg_rd);
    cover property (wake_pulse);
endmodule // hsel_spi_slave_chk

// ==== bench/hsel_spi_master.sv ====
// spi master model standing on the host side
`timescale 1ns/1ns
module hsel_spi_master (
    // spi lines
    output logic sck,
    output logic mosi,
    output logic nss_n,
    input wire logic miso
);
    initial begin
        sck = 1'h0;
        mosi = 1'h0;
        nss_n = 1'h1;
    end
    // select framing, clock low at rest
    // steps of 400 ns keep every change on a falling system clock edge
    task automatic frame(input logic go);
        #400;
        nss_n = ~go;
        #400;
        // released line shows the inverse, not the last bit
        if (!go) mosi = ~mosi;
    endtask
    // msb first, 800 ns per bit
    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        for (int i = 7; i > 7 - nbits; i--) begin
            mosi = tx[i];
            #400 sck = 1'h1;
            rx[i] = miso;
            #400 sck = 1'h0;
        end
    endtask
endmodule // hsel_spi_master

// ==== bench/hsel_spi_slave_tb.sv ====
// testbench for the host port selector and spi slave
`timescale 1ns/1ns
`include "hsel_defs.svh"
module hsel_spi_slave_tb;
    logic sys_clk;
    logic rstn;
    logic wake_pulse;
    logic strap_0;
    logic strap_1;
    logic sck, mosi, nss_n, miso, oe, miso_q, valid, wr, rd;
    logic [1:0] ptype;
    logic [6:0] addr;
    logic [7:0] wdata, rx;
    wire [7:0] rdata = {addr, 1'h1};
    logic [15:0] log_q[$];
    int num_errors = 0;
    int checked = 0;
    assign miso = oe ? miso_q : 1'hZ;
    initial begin
        sys_clk = 1'h0;
        forever #50 sys_clk = ~sys_clk;
    end
    hsel_spi_master i_mst (.sck(sck), .mosi(mosi), .nss_n(nss_n), .miso(miso));
    hsel_spi_slave i_dut (.sys_clk(sys_clk), .rstn(rstn), .wake_pulse(wake_pulse),
        .host_type_strap_0(strap_0), .host_type_strap_1(strap_1), .host_pin_0(mosi),
        .host_pin_1(sck), .host_pin_3(nss_n), .host_pin_2_out(miso_q), .host_pin_2_oe(oe),
        .port_type(ptype), .port_valid(valid), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata));
    always @(posedge sys_clk) begin
        if (wr === 1'h1) log_q.push_back({1'h0, addr, wdata});
        if (rd === 1'h1) log_q.push_back({1'h1, addr, 8'h00});
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic pop_check(input logic [15:0] exp);
        logic [15:0] v;
        v = 'x;
        if (log_q.size() > 0) v = log_q.pop_front();
        check(v, exp);
    endtask
    task automatic report_and_stop;
        $display("errors %0d, checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic t_partial;
        i_mst.frame(1'h1);
        i_mst.xfer(8'h88, 4, rx);
        i_mst.frame(1'h0);
        check(16'(log_q.size()), 16'h0000);
        check({15'h0000, oe}, 16'h0000);
    endtask
    task automatic t_write(input logic [6:0] a, input logic [6:0] a2);
        i_mst.frame(1'h1);
        i_mst.xfer({a, 1'h0}, 8, rx);
        i_mst.xfer(8'hA5, 8, rx);
        i_mst.xfer(8'h3C, 8, rx);
        i_mst.frame(1'h0);
        pop_check({1'h0, a, 8'hA5});
        pop_check({1'h0, a2, 8'h3C});
    endtask
    task automatic t_read;
        i_mst.frame(1'h1);
        check({15'h0000, oe}, 16'h0001);
        i_mst.xfer({7'h20, 1'h1}, 8, rx);
        i_mst.xfer({7'h33, 1'h1}, 8, rx);
        check(16'(rx), {8'h00, 7'h20, 1'h1});
        i_mst.xfer(8'h00, 8, rx);
        check(16'(rx), {8'h00, 7'h33, 1'h1});
        i_mst.frame(1'h0);
        pop_check({1'h1, 7'h20, 8'h00});
        pop_check({1'h1, 7'h33, 8'h00});
        // the closing 00h byte is fetched as well
        pop_check({1'h1, 7'h00, 8'h00});
    endtask
    task automatic t_wake;
        hsel_pkg::hsel_port_type exp[4];
        hsel_pkg::hsel_port_type prev;
        exp = '{hsel_pkg::HSEL_UART, hsel_pkg::HSEL_I2C, hsel_pkg::HSEL_SPI, hsel_pkg::HSEL_I2CL};
        prev = hsel_pkg::HSEL_SPI;
        for (int i = 0; i < 4; i++) begin
            {strap_1, strap_0} = 2'(i);
            repeat (20) @(negedge sys_clk);
            check(16'(ptype), 16'(prev));
            wake_pulse = 1'h1;
            @(negedge sys_clk) wake_pulse = 1'h0;
            check({15'h0000, valid}, 16'h0000);
            repeat (20) @(negedge sys_clk);
            check(16'(ptype), 16'(exp[i]));
            check({15'h0000, valid}, 16'h0001);
            prev = exp[i];
        end
        i_mst.frame(1'h1);
        i_mst.xfer(8'h20, 8, rx);
        i_mst.frame(1'h0);
        check(16'(log_q.size()), 16'h0000);
    endtask
    initial begin
        // straps select spi; every input starts at its idle level
        rstn = 1'h0;
        wake_pulse = 1'h0;
        {strap_1, strap_0} = 2'h2;
        repeat (16) @(negedge sys_clk);
        rstn = 1'h1;
        repeat (20) @(negedge sys_clk);
        check({14'h0000, ptype}, 16'(hsel_pkg::HSEL_SPI));
        check({15'h0000, valid}, 16'h0001);
        t_partial();
        t_write(7'h10, 7'h11);
        t_write(`HSEL_FIFO_ADDR, `HSEL_FIFO_ADDR);
        t_read();
        t_wake();
        report_and_stop();
    end
    // limit well beyond the expected run of about 100 us
    initial begin
        #400000;
        num_errors++;
        report_and_stop();
    end
endmodule // hsel_spi_slave_tb
bind hsel_spi_slave hsel_spi_slave_chk i_chk (.sys_clk, .rstn, .wake_pulse, .host_pin_1,
    .host_pin_3, .host_pin_2_out, .host_pin_2_oe, .port_type, .port_valid, .reg_wr, .reg_rd);
